// ### tcrp_pkg.sv
// Purpose: shared constants for the 8-bit reload/pwm timer-counter
// Assumes: 32-bit AXI4-Lite register access, 12-bit byte address
// Notes:   register byte address is four times its index
package tcrp_pkg;

   localparam int          AXI_AW      = 12;
   localparam int          AXI_DW      = 32;

   // register indices, byte address = index * 4
   localparam logic [9:0]  IDX_MODE    = 10'h0DA;
   localparam logic [9:0]  IDX_COUNT   = 10'h0DB;
   localparam logic [9:0]  IDX_RELOAD  = 10'h0CD;
   localparam logic [9:0]  IDX_STATUS  = 10'h0E0;

   // mode_control field positions
   localparam int          MODE_EN     = 7;
   localparam int          MODE_RATE_H = 6;
   localparam int          MODE_RATE_L = 4;
   localparam int          MODE_CKS    = 3;
   localparam int          MODE_ALOAD  = 2;
   localparam int          MODE_TOUT   = 1;
   localparam int          MODE_PWM    = 0;

   // status register field positions
   localparam int          STAT_FLAG   = 0;
   localparam int          STAT_IEN    = 1;
   localparam int          STAT_EVIRQ  = 2;

   localparam logic [7:0]  MODE_RST    = 8'h00;
   localparam logic [7:0]  COUNT_RST   = 8'h00;
   localparam logic [7:0]  RELOAD_RST  = 8'h00;
   localparam logic [7:0]  PRE_RST     = 8'h00;
   localparam logic [7:0]  FULL_SCALE  = 8'hFF;
   localparam logic [7:0]  ZERO_SCALE  = 8'h00;
   localparam logic [7:0]  ONE_STEP    = 8'h01;

   // pwm overflow boundaries as count masks
   localparam logic [7:0]  MASK_N256   = 8'hFF;
   localparam logic [7:0]  MASK_N64    = 8'h3F;
   localparam logic [7:0]  MASK_N32    = 8'h1F;
   localparam logic [7:0]  MASK_N16    = 8'h0F;

   localparam logic [7:0]  IRQ_VECTOR  = 8'h08;

   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

endpackage

// ### tcrp_edge_sync.sv
// Purpose: synchronise the event pin and flag its falling edges
// Assumes: pin is asynchronous to aclk
// Notes:   fall_pulse lags the pin by three clock edges
module tcrp_edge_sync (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic pin_in,
   output logic      fall_pulse
);
   import tcrp_pkg::*;

   logic meta_r;
   logic sync_r;
   logic prev_r;
   logic fall_r;
   logic meta_nxt;
   logic sync_nxt;
   logic prev_nxt;
   logic fall_nxt;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      meta_nxt = pin_in;
      sync_nxt = meta_r;
      prev_nxt = sync_r;
      // the second and third stages feed the edge detector
      fall_nxt = prev_r & ~sync_r;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_r <= 1'b1;
         sync_r <= 1'b1;
         prev_r <= 1'b1;
         fall_r <= 1'b0;
      end else begin
         meta_r <= meta_nxt;
         sync_r <= sync_nxt;
         prev_r <= prev_nxt;
         fall_r <= fall_nxt;
      end
   end

   assign fall_pulse = fall_r;

endmodule

// ### tcrp_timer.sv
// Purpose: 8-bit up timer/counter with prescaler, reload, toggle and pwm output
// Assumes: aclk is the instruction clock, AXI4-Lite register access
// Notes:   one write and one read outstanding; registers sit in wdata[7:0]
//
// Added by the designer: the AXI4-Lite interface to the registers.

// Operation
// - count holds when disabled, steps when enabled
// - overflow when count wraps full to zero
// - overflow sets sticky flag, software clears
// - flag with enable requests vector 8 interrupt
// - reload by auto-reload bit, forced in pwm
// - reload write applies at next overflow, or at once to the pwm match while disabled
// - green mode keeps running, never wakes
// - source bit picks prescaler or event pin
// - rate field divides by 256 down to 2
// - without pwm counter spans 256 steps
// - pwm bit routes pwm to shared pin
// - toggle bit drives square wave when no pwm
// - auto-reload bit acts only without pwm; here in pwm it also picks the 32 or 16 boundary
// - event mode holds pin irq flag low
// - toggle output flips on every overflow
// - pwm high at period start, low on match
// - pwm boundary 256, 64, 32 or 16
// - event mode counts input falling edges
module tcrp_timer (
   input  wire logic                         aclk,
   input  wire logic                         aresetn,
   input  wire logic [tcrp_pkg::AXI_AW-1:0]  s_axi_awaddr,
   input  wire logic                         s_axi_awvalid,
   output logic                              s_axi_awready,
   input  wire logic [tcrp_pkg::AXI_DW-1:0]  s_axi_wdata,
   input  wire logic [3:0]                   s_axi_wstrb,
   input  wire logic                         s_axi_wvalid,
   output logic                              s_axi_wready,
   output logic [1:0]                        s_axi_bresp,
   output logic                              s_axi_bvalid,
   input  wire logic                         s_axi_bready,
   input  wire logic [tcrp_pkg::AXI_AW-1:0]  s_axi_araddr,
   input  wire logic                         s_axi_arvalid,
   output logic                              s_axi_arready,
   output logic [tcrp_pkg::AXI_DW-1:0]       s_axi_rdata,
   output logic [1:0]                        s_axi_rresp,
   output logic                              s_axi_rvalid,
   input  wire logic                         s_axi_rready,
   input  wire logic                         event_input_pin,
   output logic                              shared_output_pin_o,
   output logic                              shared_output_pin_oe,
   output logic                              irq_req,
   output logic [7:0]                        irq_vector,
   output logic                              wakeup_req
);
   import tcrp_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // bus slave state
   logic                awready_r, awready_nxt;
   logic                wready_r,  wready_nxt;
   logic                bvalid_r,  bvalid_nxt;
   logic [1:0]          bresp_r,   bresp_nxt;
   logic                arready_r, arready_nxt;
   logic                rvalid_r,  rvalid_nxt;
   logic [1:0]          rresp_r,   rresp_nxt;
   logic [AXI_DW-1:0]   rdata_r,   rdata_nxt;
   logic                awheld_r,  awheld_nxt;
   logic                wheld_r,   wheld_nxt;
   logic [9:0]          waddr_r,   waddr_nxt;
   logic [7:0]          wdata_r,   wdata_nxt;
   logic                wstrb_r,   wstrb_nxt;
   // timer state
   logic [7:0]          mode_r,    mode_nxt;
   logic [7:0]          count_r,   count_nxt;
   logic [7:0]          staged_r,  staged_nxt;
   logic [7:0]          active_r,  active_nxt;
   logic [7:0]          pre_r,     pre_nxt;
   logic                flag_r,    flag_nxt;
   logic                ien_r,     ien_nxt;
   logic                evflag_r,  evflag_nxt;
   logic                tog_r,     tog_nxt;
   logic                pwm_r,     pwm_nxt;
   logic                pin_o_r,   pin_o_nxt;
   logic                pin_oe_r,  pin_oe_nxt;
   logic                irq_r,     irq_nxt;
   logic                wr_fire;
   logic                wr_hit;
   logic                wr_mode, wr_count, wr_reload, wr_status;
   logic                en, cks, aload, tout, pwm_en;
   logic [2:0]          rate;
   logic [7:0]          pmask;
   logic [7:0]          rmask;
   logic                pre_tick, ev_fall, tick, ovf, reload_act;
   ////////////////////////////////////////////////////////////////////////////
   // event pin synchroniser and edge detector
   tcrp_edge_sync u_edge (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .pin_in     (event_input_pin),
      .fall_pulse (ev_fall)
   );

   ////////////////////////////////////////////////////////////////////////////
   // write decode: a write lands once address and data are both held
   assign wr_fire   = awheld_r & wheld_r & ~bvalid_r;
   assign wr_hit    = (waddr_r == IDX_MODE) | (waddr_r == IDX_COUNT) |
                      (waddr_r == IDX_RELOAD) | (waddr_r == IDX_STATUS);
   assign wr_mode   = wr_fire & wstrb_r & (waddr_r == IDX_MODE);
   assign wr_count  = wr_fire & wstrb_r & (waddr_r == IDX_COUNT);
   assign wr_reload = wr_fire & wstrb_r & (waddr_r == IDX_RELOAD);
   assign wr_status = wr_fire & wstrb_r & (waddr_r == IDX_STATUS);

   always_comb begin
      awheld_nxt  = awheld_r;
      wheld_nxt   = wheld_r;
      waddr_nxt   = waddr_r;
      wdata_nxt   = wdata_r;
      wstrb_nxt   = wstrb_r;
      bvalid_nxt  = bvalid_r;
      bresp_nxt   = bresp_r;
      rvalid_nxt  = rvalid_r;
      rresp_nxt   = rresp_r;
      rdata_nxt   = rdata_r;
      arready_nxt = arready_r | ~rvalid_r;                    // opens once reset is over
      if (s_axi_awvalid && awready_r) begin
         awheld_nxt = 1'b1;
         waddr_nxt  = s_axi_awaddr[AXI_AW-1:2];
      end
      if (s_axi_wvalid && wready_r) begin
         wheld_nxt = 1'b1;
         wdata_nxt = s_axi_wdata[7:0];
         wstrb_nxt = s_axi_wstrb[0];
      end
      if (wr_fire) begin
         awheld_nxt = 1'b0;
         wheld_nxt  = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt  = wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
         bvalid_nxt = 1'b0;
      end
      // a channel reopens only after its response has been taken
      awready_nxt = ~awheld_nxt & ~bvalid_nxt;
      wready_nxt  = ~wheld_nxt & ~bvalid_nxt;
      if (s_axi_arvalid && arready_r) begin
         arready_nxt = 1'b0;
         rvalid_nxt  = 1'b1;
         rresp_nxt   = RESP_OKAY;
         case (s_axi_araddr[AXI_AW-1:2])
            IDX_MODE:   rdata_nxt = {24'h000000, mode_r};
            IDX_COUNT:  rdata_nxt = {24'h000000, count_r};
            // reload buffer is write-only
            IDX_RELOAD: rdata_nxt = 32'h00000000;
            IDX_STATUS: rdata_nxt = {29'h00000000, evflag_r, ien_r, flag_r};
            default: begin
               rdata_nxt = 32'h00000000;
               rresp_nxt = RESP_SLVERR;
            end
         endcase
      end else if (rvalid_r && s_axi_rready) begin
         rvalid_nxt  = 1'b0;
         arready_nxt = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_r <= 1'b0;
         wready_r  <= 1'b0;
         bvalid_r  <= 1'b0;
         bresp_r   <= RESP_OKAY;
         arready_r <= 1'b0;
         rvalid_r  <= 1'b0;
         rresp_r   <= RESP_OKAY;
         rdata_r   <= 32'h00000000;
         awheld_r  <= 1'b0;
         wheld_r   <= 1'b0;
         waddr_r   <= 10'h000;
         wdata_r   <= 8'h00;
         wstrb_r   <= 1'b0;
      end else begin
         awready_r <= awready_nxt;
         wready_r  <= wready_nxt;
         bvalid_r  <= bvalid_nxt;
         bresp_r   <= bresp_nxt;
         arready_r <= arready_nxt;
         rvalid_r  <= rvalid_nxt;
         rresp_r   <= rresp_nxt;
         rdata_r   <= rdata_nxt;
         awheld_r  <= awheld_nxt;
         wheld_r   <= wheld_nxt;
         waddr_r   <= waddr_nxt;
         wdata_r   <= wdata_nxt;
         wstrb_r   <= wstrb_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // clock selection and overflow boundary
   assign en      = mode_r[MODE_EN];
   assign rate    = mode_r[MODE_RATE_H:MODE_RATE_L];
   assign cks     = mode_r[MODE_CKS];
   assign aload   = mode_r[MODE_ALOAD];
   assign tout    = mode_r[MODE_TOUT];
   assign pwm_en  = mode_r[MODE_PWM];
   assign pmask   = FULL_SCALE >> rate;
   assign pre_tick = (pre_r & pmask) == pmask;
   assign tick    = cks ? ev_fall : pre_tick;

   always_comb begin
      case ({pwm_en & ~cks, aload, tout})
         3'b101:  rmask = MASK_N64;
         3'b110:  rmask = MASK_N32;
         3'b111:  rmask = MASK_N16;
         default: rmask = MASK_N256;
      endcase
   end
   assign ovf        = en & tick & ((count_r & rmask) == rmask);
   assign reload_act = pwm_en | aload;

   ////////////////////////////////////////////////////////////////////////////
   // counter, flags and output pin
   always_comb begin
      mode_nxt   = mode_r;
      count_nxt  = count_r;
      staged_nxt = staged_r;
      active_nxt = active_r;
      flag_nxt   = flag_r;
      ien_nxt    = ien_r;
      evflag_nxt = evflag_r;
      tog_nxt    = tog_r;
      pwm_nxt    = pwm_r;
      // restart the prescaler so the first period after enabling is whole
      pre_nxt    = en ? pre_r + ONE_STEP : PRE_RST;
      if (ovf) begin
         active_nxt = staged_r;
         tog_nxt    = ~tog_r;
         pwm_nxt    = 1'b1;
         if (reload_act) begin
            count_nxt = pwm_en ? ZERO_SCALE : staged_r;
         end else begin
            count_nxt = count_r + ONE_STEP;
         end
      end else if (en && tick) begin
         count_nxt = count_r + ONE_STEP;
      end
      if (!ovf && en && pwm_en && ((count_r & rmask) == (active_r & rmask))) begin
         pwm_nxt = 1'b0;
      end
      if (wr_mode) begin
         mode_nxt = wdata_r;
      end
      // a software write to the count overrides the step in that cycle
      if (wr_count) begin
         count_nxt = wdata_r;
      end
      if (wr_reload) begin
         staged_nxt = wdata_r;
         if (!en) begin
            active_nxt = wdata_r;
         end
      end
      if (wr_status) begin
         ien_nxt    = wdata_r[STAT_IEN];
         flag_nxt   = flag_r & wdata_r[STAT_FLAG];
         evflag_nxt = evflag_r & wdata_r[STAT_EVIRQ];
      end
      // a set in the clearing cycle wins
      if (ovf) begin
         flag_nxt = 1'b1;
      end
      if (cks) begin
         evflag_nxt = 1'b0;
      end else if (ev_fall) begin
         evflag_nxt = 1'b1;
      end
      pin_o_nxt  = pwm_en ? pwm_r : tog_r;
      pin_oe_nxt = pwm_en | tout;
      irq_nxt    = flag_r & ien_r;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_r   <= MODE_RST;
         count_r  <= COUNT_RST;
         staged_r <= RELOAD_RST;
         active_r <= RELOAD_RST;
         pre_r    <= PRE_RST;
         flag_r   <= 1'b0;
         ien_r    <= 1'b0;
         evflag_r <= 1'b0;
         tog_r    <= 1'b0;
         pwm_r    <= 1'b1;
         pin_o_r  <= 1'b0;
         pin_oe_r <= 1'b0;
         irq_r    <= 1'b0;
      end else begin
         mode_r   <= mode_nxt;
         count_r  <= count_nxt;
         staged_r <= staged_nxt;
         active_r <= active_nxt;
         pre_r    <= pre_nxt;
         flag_r   <= flag_nxt;
         ien_r    <= ien_nxt;
         evflag_r <= evflag_nxt;
         tog_r    <= tog_nxt;
         pwm_r    <= pwm_nxt;
         pin_o_r  <= pin_o_nxt;
         pin_oe_r <= pin_oe_nxt;
         irq_r    <= irq_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign s_axi_awready        = awready_r;
   assign s_axi_wready         = wready_r;
   assign s_axi_bvalid         = bvalid_r;
   assign s_axi_bresp          = bresp_r;
   assign s_axi_arready        = arready_r;
   assign s_axi_rvalid         = rvalid_r;
   assign s_axi_rresp          = rresp_r;
   assign s_axi_rdata          = rdata_r;
   assign shared_output_pin_o  = pin_o_r;
   assign shared_output_pin_oe = pin_oe_r;
   assign irq_req              = irq_r;
   // vector and wake line are constants; green mode changes nothing here
   assign irq_vector           = IRQ_VECTOR;
   assign wakeup_req           = 1'b0;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_count_hold: assert property (!en && !wr_count |=> $stable(count_r))
      else $error("count moved while disabled");
   a_count_step: assert property (tick && en && !ovf && !wr_count
      |=> count_r == $past(count_r) + ONE_STEP)
      else $error("count did not step by one");
   a_ovf_wrap: assert property (en && tick && !pwm_en && !aload && !wr_count
      && count_r == FULL_SCALE |=> count_r == ZERO_SCALE && flag_r)
      else $error("full scale did not wrap to zero");
   a_flag_sticky: assert property (flag_r && !wr_status |=> flag_r)
      else $error("overflow flag dropped without software");
   a_irq_request: assert property (flag_r && ien_r |=> irq_req)
      else $error("interrupt not raised");
   a_reload_next: assert property (ovf && !pwm_en && aload && !wr_count
      |=> count_r == $past(staged_r))
      else $error("reload not applied at overflow");
   a_pre_rate: assert property (en && !cks && rate == 3'h7 && !wr_mode
      |-> ##1 (tick || $past(tick)))
      else $error("divide by two rate missed");
   a_event_quiet: assert property (cks |=> !evflag_r)
      else $error("pin irq flag set in event mode");
   a_toggle_flip: assert property (ovf |=> tog_r != $past(tog_r))
      else $error("toggle did not flip on overflow");
   a_pwm_match: assert property (en && pwm_en && !ovf && !wr_mode
      && (count_r & rmask) == (active_r & rmask) |=> !pwm_r ##1 pin_o_r == 1'b0)
      else $error("pwm did not fall on match");
   a_pwm_bound: assert property (pwm_en && !cks && aload && tout && en
      && tick && count_r[3:0] == 4'hF && !wr_count |=> count_r == ZERO_SCALE)
      else $error("pwm 16 boundary missed");
   a_no_wake: assert property (ovf |=> !wakeup_req)
      else $error("wake request raised");

   c_ovf_irq:   cover property (ovf ##1 flag_r && ien_r ##2 irq_req);
   c_event_ovf: cover property (cks && ovf);
   c_pwm_cycle: cover property (pwm_en && !pwm_r ##[1:300] ovf);
   c_toggle:    cover property (tout && ovf ##[1:600] ovf);

endmodule

// ### tcrp_pin_model.sv
// Purpose: far side of the timer pins: event source and pulled-up shared pin
// Assumes: event pin idles high, shared pin has a pull-up
// Notes:   pulses are slow enough for the two-flop synchroniser
module tcrp_pin_model (
   input  wire logic aclk,
   input  wire logic pin_o,
   input  wire logic pin_oe,
   output logic      event_pin,
   output logic      pin_level
);
   timeunit 1ns;
   timeprecision 1ps;

   initial event_pin = 1'b1;

   // pull-up wins whenever the block leaves the pin as gpio
   assign pin_level = pin_oe ? pin_o : 1'b1;

   ////////////////////////////////////////////////////////////////////////////
   // each pulse gives exactly one falling edge
   task automatic pulse(input int n);
      repeat (n) begin
         @(posedge aclk);
         event_pin <= 1'b0;
         repeat (4) @(posedge aclk);
         event_pin <= 1'b1;
         repeat (4) @(posedge aclk);
      end
   endtask
endmodule

// ### tb_top.sv
// Purpose: self-checking bench for the reload/pwm timer-counter
// Assumes: registers reached over AXI4-Lite, data in wdata[7:0]
// Notes:   cycle figures are counted at the 40 MHz clock
module tb_top;
   import tcrp_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   localparam logic [11:0] A_MODE = {IDX_MODE, 2'b00};
   localparam logic [11:0] A_CNT  = {IDX_COUNT, 2'b00};
   localparam logic [11:0] A_REL  = {IDX_RELOAD, 2'b00};
   localparam logic [11:0] A_STAT = {IDX_STATUS, 2'b00};

   logic        aclk    = 1'b0;
   logic        aresetn = 1'b0;
   logic [11:0] awaddr  = 12'h000;
   logic [11:0] araddr  = 12'h000;
   logic [31:0] wdata   = 32'h00000000;
   logic        awvalid = 1'b0;
   logic        wvalid  = 1'b0;
   logic        bready  = 1'b0;
   logic        arvalid = 1'b0;
   logic        rready  = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   logic        pin_o, pin_oe, irq_req, wakeup_req, ev_pin, pin_lvl;
   logic [7:0]  irq_vector;
   int          fail_count = 0;
   int          tests_run  = 0;

   always #12.5 aclk = ~aclk;

   tcrp_timer uut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .event_input_pin(ev_pin),
      .shared_output_pin_o(pin_o), .shared_output_pin_oe(pin_oe),
      .irq_req(irq_req), .irq_vector(irq_vector), .wakeup_req(wakeup_req));

   tcrp_pin_model pm (.aclk(aclk), .pin_o(pin_o), .pin_oe(pin_oe),
      .event_pin(ev_pin), .pin_level(pin_lvl));

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk("bresp", {30'h0, RESP_OKAY}, {30'h0, bresp});
   endtask

   task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask

   task automatic rchk(input string n, input logic [11:0] a, input logic [7:0] e);
      logic [31:0] d;
      logic [1:0]  r;
      rd(a, d, r);
      chk(n, {24'h0, e}, d);
      chk("rresp", {30'h0, RESP_OKAY}, {30'h0, r});
   endtask

   // a stuck pin gives up after 600 cycles so the gap check fails
   task automatic wait_change(output int n);
      logic p;
      p = pin_lvl;
      n = 0;
      while (pin_lvl === p && n < 600) begin
         @(posedge aclk);
         n++;
      end
   endtask

   task automatic wait_irq;
      int n;
      n = 0;
      while (irq_req !== 1'b1 && n < 400) begin
         @(posedge aclk);
         n++;
      end
      chk("irq_req", 32'h1, {31'h0, irq_req});
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [31:0] d;
      logic [1:0]  r;
      int          g, h, l, n;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      rchk("mode", A_MODE, MODE_RST);
      rchk("count", A_CNT, COUNT_RST);
      rchk("status", A_STAT, 8'h00);
      rchk("reload", A_REL, RELOAD_RST);
      rd(12'h004, d, r);
      chk("unmapped data", 32'h0, d);
      chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, r});
      chk("irq_vector", 32'h00000008, {24'h0, irq_vector});
      wr(A_CNT, 8'h55);
      repeat (40) @(posedge aclk);
      rchk("held count", A_CNT, 8'h55);
      chk("idle oe", 32'h0, {31'h0, pin_oe});
      // reload of 0xFF makes every tick an overflow, so pin gaps show the rate
      for (int k = 0; k < 8; k++) begin
         wr(A_MODE, 8'h00);
         wr(A_REL, 8'hFF);
         wr(A_CNT, 8'hFF);
         wr(A_MODE, {1'b0, k[2:0], 4'h6});
         wr(A_MODE, {1'b1, k[2:0], 4'h6});
         repeat (3) wait_change(g);
         chk("toggle gap", 32'(256 >> k), 32'(g));
         chk("toggle oe", 32'h1, {31'h0, pin_oe});
      end
      wr(A_MODE, 8'h00);
      wr(A_STAT, 8'h02);
      rchk("flag cleared", A_STAT, 8'h02);
      wr(A_CNT, 8'hFF);
      wr(A_MODE, 8'h80);
      wait_irq;
      rchk("wrapped", A_CNT, 8'h00);
      repeat (300) @(posedge aclk);
      rchk("sticky flag", A_STAT, 8'h03);
      chk("wakeup", 32'h0, {31'h0, wakeup_req});
      wr(A_MODE, 8'h00);
      wr(A_STAT, 8'h02);
      repeat (3) @(posedge aclk);
      chk("irq off", 32'h0, {31'h0, irq_req});
      wr(A_REL, 8'hF0);
      wr(A_CNT, 8'hFF);
      wr(A_MODE, 8'h04);
      wr(A_MODE, 8'h84);
      wr(A_REL, 8'h80);
      rchk("undisturbed", A_CNT, 8'hFF);
      wait_irq;
      rchk("reloaded", A_CNT, 8'h80);
      // k[1] is auto reload, k[0] is toggle: boundaries 256, 64, 32, 16
      for (int k = 0; k < 4; k++) begin
         n = (k == 0) ? 256 : (128 >> k);
         wr(A_MODE, 8'h00);
         wr(A_REL, 8'(n / 4));
         wr(A_CNT, 8'h00);
         wr(A_MODE, {5'b01110, k[1:0], 1'b1});
         wr(A_MODE, {5'b11110, k[1:0], 1'b1});
         do wait_change(g); while (pin_lvl !== 1'b1);
         wait_change(h);
         wait_change(l);
         chk("pwm period", 32'(2 * n), 32'(h + l));
         chk("pwm high", 32'h1, 32'(h >= n / 2 && h <= n / 2 + 2));
         chk("pwm oe", 32'h1, {31'h0, pin_oe});
      end
      wr(A_MODE, 8'h00);
      wr(A_STAT, 8'h00);
      pm.pulse(1);
      repeat (4) @(posedge aclk);
      rchk("pin irq", A_STAT, 8'h04);
      wr(A_STAT, 8'h00);
      wr(A_CNT, 8'h00);
      wr(A_MODE, 8'h08);
      wr(A_MODE, 8'h88);
      pm.pulse(5);
      repeat (4) @(posedge aclk);
      rchk("events", A_CNT, 8'h05);
      rchk("pin irq held", A_STAT, 8'h00);
      test_done;
   end

   initial begin
      repeat (40000) @(posedge aclk);
      fail_count++;
      $display("[ERR] watchdog expected finish seen timeout");
      test_done;
   end
endmodule
